/* src/t8cu_counter_unit.sv */
// Counter unit of the 8-bit timer: clock select, counter, compare, flags and masks
`timescale 1ns/1ps
`default_nettype none
module t8cu_counter_unit (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire t8cu_pkg::t8cu_bus_req_s bus_req,
  output logic [t8cu_pkg::DATA_W-1:0] rd_data_q,
  input wire logic [2:0] irq_ack,
  input wire logic external_count_pin,
  output logic irq_overflow_q,
  output logic irq_compare_a_q,
  output logic irq_compare_b_q,
  output logic at_bottom_q,
  output logic at_max_q,
  output logic timer_tick_q
);
  import t8cu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State and decode

  logic [DATA_W-1:0] count_q;
  logic [DATA_W-1:0] count_d;
  logic [DATA_W-1:0] cmp_a_buf_q;
  logic [DATA_W-1:0] cmp_b_buf_q;
  logic [DATA_W-1:0] cmp_a_q;
  logic [DATA_W-1:0] cmp_b_q;
  logic [1:0] ctrl_a_q;
  logic [3:0] ctrl_b_q;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic [2:0] mask_q;
  logic [PRESCALE_W-1:0] prescale_q;
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic block_q;
  t8cu_dir_e dir_q;
  t8cu_dir_e dir_d;
  logic [2:0] waveform_mode_field;
  logic [2:0] clock_select_field;
  logic [DATA_W-1:0] top_val;
  logic tick;
  logic ovf_set;
  logic match_a_set;
  logic match_b_set;
  logic buf_load;
  logic wr_count;

  function automatic logic wr_hit(input t8cu_bus_req_s req, input logic [ADDR_W-1:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  // Odd modes are the PWM modes
  function automatic logic is_pwm(input logic [2:0] mode);
    is_pwm = mode[0];
  endfunction

  function automatic logic top_is_cmp(input logic [2:0] mode);
    top_is_cmp = (mode == WGM_CTC) || (mode == WGM_PC_CMP) || (mode == WGM_FAST_CMP);
  endfunction

  assign waveform_mode_field = {ctrl_b_q[CTRL_B_MODE_HI], ctrl_a_q}; // [R12]
  assign clock_select_field = ctrl_b_q[2:0];
  assign top_val = top_is_cmp(waveform_mode_field) ? cmp_a_q : COUNT_MAX; // [R4]
  assign wr_count = wr_hit(bus_req, OFS_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // Clock select and external pin

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + PRESCALE_W'(1);
    end
  end

  // Third flop gives edge detection without touching the metastable stage
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_meta_q <= external_count_pin; // [R22]
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  always_comb begin
    case (clock_select_field) // [R5] [R6]
      CS_STOP: tick = 1'b0; // [R7]
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = &prescale_q[2:0];
      CS_DIV64: tick = &prescale_q[5:0];
      CS_DIV256: tick = &prescale_q[7:0];
      CS_DIV1024: tick = &prescale_q;
      CS_EXT_FALL: tick = ext_prev_q && !ext_sync_q; // [R22]
      CS_EXT_RISE: tick = !ext_prev_q && ext_sync_q; // [R22]
      default: tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter sequence

  always_comb begin
    count_d = count_q;
    dir_d = dir_q;
    ovf_set = 1'b0;
    if (tick) begin
      case (waveform_mode_field) // [R10] [R12]
        WGM_CTC: begin
          count_d = (count_q == top_val) ? COUNT_BOTTOM : count_q + COUNT_STEP; // [R11]
          ovf_set = (count_q == COUNT_MAX); // [R13]
        end
        WGM_FAST_MAX, WGM_FAST_CMP: begin
          count_d = (count_q == top_val) ? COUNT_BOTTOM : count_q + COUNT_STEP; // [R11]
          ovf_set = (count_q == top_val); // [R13]
        end
        WGM_PC_MAX, WGM_PC_CMP: begin
          if (dir_q == DIR_UP) begin
            if (count_q >= top_val) begin
              dir_d = DIR_DOWN;
              count_d = (count_q == COUNT_BOTTOM) ? COUNT_BOTTOM : count_q - COUNT_STEP;
            end else begin
              count_d = count_q + COUNT_STEP;
            end
          end else if (count_q == COUNT_BOTTOM) begin
            dir_d = DIR_UP;
            ovf_set = 1'b1; // [R13]
            count_d = (top_val == COUNT_BOTTOM) ? COUNT_BOTTOM : count_q + COUNT_STEP;
          end else begin
            count_d = count_q - COUNT_STEP;
          end
        end
        default: begin
          count_d = count_q + COUNT_STEP;
          ovf_set = (count_q == COUNT_MAX); // [R13]
        end
      endcase
    end
    // Software write overrides the count the tick asked for
    if (wr_count) begin
      count_d = bus_req.wdata; // [R8] [R9]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= RST_BYTE; // [R21]
      dir_q <= DIR_UP;
    end else begin
      count_q <= count_d; // [R1]
      dir_q <= dir_d;
    end
  end

  // Block persists until a tick consumes it, so a stopped timer still honours it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1; // [R19]
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare registers

  // Fast modes load on the wrap to BOTTOM, phase correct at TOP, so pulses stay symmetric
  always_comb begin
    if (waveform_mode_field == WGM_FAST_MAX || waveform_mode_field == WGM_FAST_CMP) begin
      buf_load = tick && (count_q == top_val); // [R17]
    end else begin
      buf_load = tick && (dir_q == DIR_UP) && (count_q >= top_val); // [R17]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_a_buf_q <= RST_BYTE; // [R21]
      cmp_b_buf_q <= RST_BYTE;
      cmp_a_q <= RST_BYTE;
      cmp_b_q <= RST_BYTE;
    end else begin
      if (wr_hit(bus_req, OFS_CMP_A)) begin
        cmp_a_buf_q <= bus_req.wdata;
      end
      if (wr_hit(bus_req, OFS_CMP_B)) begin
        cmp_b_buf_q <= bus_req.wdata;
      end
      if (!is_pwm(waveform_mode_field)) begin
        if (wr_hit(bus_req, OFS_CMP_A)) begin
          cmp_a_q <= bus_req.wdata; // [R17]
        end
        if (wr_hit(bus_req, OFS_CMP_B)) begin
          cmp_b_q <= bus_req.wdata; // [R17]
        end
      end else if (buf_load) begin
        cmp_a_q <= cmp_a_buf_q; // [R17]
        cmp_b_q <= cmp_b_buf_q;
      end
    end
  end

  // Counter value held over the previous tick is compared, so the flag lands one tick later
  assign match_a_set = tick && !block_q && (count_q == cmp_a_q); // [R14] [R18] [R19]
  assign match_b_set = tick && !block_q && (count_q == cmp_b_q); // [R14] [R18] [R19]

  ////////////////////////////////////////////////////////////////////////////
  // Control, flags and masks

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_q <= RST_CTRL_A; // [R21]
      ctrl_b_q <= RST_CTRL_B;
      mask_q <= RST_FLAGS;
    end else begin
      if (wr_hit(bus_req, OFS_CTRL_A)) begin
        ctrl_a_q <= bus_req.wdata[1:0]; // [R12]
      end
      if (wr_hit(bus_req, OFS_CTRL_B)) begin
        ctrl_b_q <= bus_req.wdata[3:0]; // [R6] [R12]
      end
      if (wr_hit(bus_req, OFS_MASK)) begin
        mask_q <= bus_req.wdata[2:0]; // [R16]
      end
    end
  end

  // Clears first, then sets, so an event in the clearing cycle is kept
  always_comb begin
    flag_d = flag_q & ~irq_ack; // [R20]
    if (wr_hit(bus_req, OFS_FLAG)) begin
      flag_d = flag_d & ~bus_req.wdata[2:0]; // [R20]
    end
    flag_d[FLAG_OVF] = flag_d[FLAG_OVF] | ovf_set; // [R13]
    flag_d[FLAG_CMP_A] = flag_d[FLAG_CMP_A] | match_a_set; // [R15]
    flag_d[FLAG_CMP_B] = flag_d[FLAG_CMP_B] | match_b_set; // [R15]
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= RST_FLAGS; // [R21]
    end else begin
      flag_q <= flag_d; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and read port

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_overflow_q <= 1'b0;
      irq_compare_a_q <= 1'b0;
      irq_compare_b_q <= 1'b0;
      at_bottom_q <= 1'b1;
      at_max_q <= 1'b0;
      timer_tick_q <= 1'b0;
    end else begin
      irq_overflow_q <= flag_q[FLAG_OVF] & mask_q[FLAG_OVF]; // [R16]
      irq_compare_a_q <= flag_q[FLAG_CMP_A] & mask_q[FLAG_CMP_A]; // [R16]
      irq_compare_b_q <= flag_q[FLAG_CMP_B] & mask_q[FLAG_CMP_B]; // [R16]
      at_bottom_q <= (count_d == COUNT_BOTTOM); // [R2]
      at_max_q <= (count_d == COUNT_MAX); // [R3]
      timer_tick_q <= tick;
    end
  end

  // Compare reads return the value software last wrote, i.e. the buffer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= RST_BYTE;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_COUNT: rd_data_q <= count_q; // [R8]
        OFS_CMP_A: rd_data_q <= cmp_a_buf_q;
        OFS_CMP_B: rd_data_q <= cmp_b_buf_q;
        OFS_CTRL_A: rd_data_q <= {6'h00, ctrl_a_q};
        OFS_CTRL_B: rd_data_q <= {4'h0, ctrl_b_q};
        OFS_FLAG: rd_data_q <= {5'h00, flag_q}; // [R16]
        OFS_MASK: rd_data_q <= {5'h00, mask_q};
        default: rd_data_q <= RST_BYTE;
      endcase
    end else begin
      rd_data_q <= RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_count_write;
    wr_count;
  endsequence

  sequence s_match_a;
    tick && !block_q && (count_q == cmp_a_q);
  endsequence

  sequence s_ext_rise;
    (clock_select_field == CS_EXT_RISE) && !ext_sync_q ##1 (clock_select_field == CS_EXT_RISE) && ext_sync_q;
  endsequence

  property p_stop_no_tick;
    (clock_select_field == CS_STOP) |-> !tick ##1 !timer_tick_q;
  endproperty
  a_stop_no_tick: assert property (p_stop_no_tick) else $error("tick while stopped"); // [R7]

  property p_cpu_priority;
    s_count_write |=> (count_q == $past(bus_req.wdata));
  endproperty
  a_cpu_priority: assert property (p_cpu_priority) else $error("counter write lost"); // [R9]

  property p_bottom_ind;
    (count_q == COUNT_BOTTOM) |-> at_bottom_q;
  endproperty
  a_bottom_ind: assert property (p_bottom_ind) else $error("bottom indication missing"); // [R2]

  property p_max_ind;
    at_max_q |-> (count_q == COUNT_MAX);
  endproperty
  a_max_ind: assert property (p_max_ind) else $error("max indication wrong"); // [R3]

  property p_normal_step;
    (tick && waveform_mode_field == WGM_NORMAL && !wr_count) |=> (count_q == $past(count_q) + COUNT_STEP);
  endproperty
  a_normal_step: assert property (p_normal_step) else $error("normal mode step wrong"); // [R10]

  property p_ctc_clear;
    (tick && waveform_mode_field == WGM_CTC && count_q == cmp_a_q && !wr_count) |=> (count_q == COUNT_BOTTOM);
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("clear at top missing"); // [R4]

  property p_ovf_normal;
    (tick && waveform_mode_field == WGM_NORMAL && count_q == COUNT_MAX) |=> flag_q[FLAG_OVF];
  endproperty
  a_ovf_normal: assert property (p_ovf_normal) else $error("overflow flag not set"); // [R13]

  property p_match_set;
    s_match_a |=> flag_q[FLAG_CMP_A];
  endproperty
  a_match_set: assert property (p_match_set) else $error("compare flag A not set"); // [R18]

  property p_match_block;
    s_count_write ##1 (tick && !flag_q[FLAG_CMP_A]) |=> !flag_q[FLAG_CMP_A];
  endproperty
  a_match_block: assert property (p_match_block) else $error("match not blocked after write"); // [R19]

  property p_direct_cmp;
    (wr_hit(bus_req, OFS_CMP_A) && !is_pwm(waveform_mode_field)) |=> (cmp_a_q == $past(bus_req.wdata));
  endproperty
  a_direct_cmp: assert property (p_direct_cmp) else $error("direct compare write lost"); // [R17]

  property p_ack_clear;
    (irq_ack[FLAG_CMP_B] && !match_b_set) |=> !flag_q[FLAG_CMP_B];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("service did not clear flag B"); // [R20]

  property p_irq_mask;
    (flag_q[FLAG_CMP_A] && mask_q[FLAG_CMP_A]) |=> irq_compare_a_q;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request not raised"); // [R16]

  property p_ext_edge;
    s_ext_rise |-> tick;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external rising edge gave no tick"); // [R22]
endmodule
`default_nettype wire

/* src/t8cu_pkg.sv */
// Package: constants, register map and carrier types of the 8-bit timer counter unit
// What this block does
// R1: Counter value and both compare values are 8-bit registers.
// R2: Counter reaching 0x00 is BOTTOM; an internal bottom indication is raised.
// R3: Counter reaching 0xFF, decimal 255, is MAX.
// R4: TOP is fixed 0xFF or compare value A, chosen by mode.
// R5: Tick comes from core clock, prescaler output or external count pin.
// R6: Clock select picks both tick source and active edge.
// R7: Clock select zero stops the counter; no ticks at all.
// R8: Software may read and write the counter with or without ticks.
// R9: Software write to the counter beats clear, increment or decrement.
// R10: Each tick clears, increments or decrements by one as mode dictates.
// R11: Clear sets every counter bit to zero.
// R12: Three-bit waveform mode: two bits in control A, one in control B.
// R13: Overflow flag set at the point the waveform mode defines.
// R14: Both compare values compared with the counter in every cycle.
// R15: A compare match sets that channel's compare flag.
// R16: Three sources share one flag register, each masked individually.
// R17: Compare values double buffered only in PWM modes, loaded at TOP/BOTTOM.
// R18: Compare flag set at the tick following counter equal compare.
// R19: A counter write blocks the match at the next tick, even stopped.
// R20: Flag cleared by interrupt service, or by software writing one.
// R21: Reset zeroes counter, compares, flags, masks; timer left stopped.
// R22: External count pin synchronised, then selected edge detected.
package t8cu_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PRESCALE_W = 10;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_COUNT = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CMP_A = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CMP_B = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL_A = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_MASK = 3'h6;
  // Field positions: control A bits 1:0 = mode low, control B bits 2:0 = clock select, bit 3 = mode high
  localparam int CTRL_B_MODE_HI = 3;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;
  // Waveform modes
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_MAX = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_MAX = 3'h3;
  localparam logic [2:0] WGM_PC_CMP = 3'h5;
  localparam logic [2:0] WGM_FAST_CMP = 3'h7;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Counter values and reset values
  localparam logic [DATA_W-1:0] COUNT_BOTTOM = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_MAX = 8'hFF;
  localparam logic [DATA_W-1:0] COUNT_STEP = 8'h01;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [1:0] RST_CTRL_A = 2'h0;
  localparam logic [3:0] RST_CTRL_B = 4'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } t8cu_bus_req_s;

  typedef enum logic {DIR_UP, DIR_DOWN} t8cu_dir_e;
endpackage

/* test/t8cu_counter_unit_test.sv */
// Self-checking testbench of the 8-bit timer counter unit
`timescale 1ns/1ps
`default_nettype none
module t8cu_counter_unit_test;
  import t8cu_pkg::*;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} t8cu_row_s;
  localparam int CYCLE_LIMIT = 20000;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  t8cu_bus_req_s bus_req = '0;
  logic [2:0] irq_ack = 3'h0;
  logic [7:0] pulse_count = 8'h00;
  logic start = 1'b0;
  logic external_count_pin;
  logic busy;
  logic [7:0] rd_data_q;
  logic irq_overflow_q, irq_compare_a_q, irq_compare_b_q, at_bottom_q, at_max_q, timer_tick_q;
  int n_ticks = 0;
  int n_max = 0;
  int mark = 0;
  logic hit;
  logic [7:0] d, d2;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  t8cu_row_s rows [7] = '{'{OFS_COUNT, 8'hA5, 8'hA5}, '{OFS_CMP_A, 8'h3C, 8'h3C}, '{OFS_CMP_B, 8'hC3, 8'hC3},
    '{OFS_CTRL_A, 8'hFF, 8'h03}, '{OFS_CTRL_B, 8'hF8, 8'h08}, '{OFS_MASK, 8'hFF, 8'h07}, '{3'h7, 8'hFF, 8'h00}};

  t8cu_counter_unit i_dut (.core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data_q(rd_data_q),
    .irq_ack(irq_ack), .external_count_pin(external_count_pin), .irq_overflow_q(irq_overflow_q),
    .irq_compare_a_q(irq_compare_a_q), .irq_compare_b_q(irq_compare_b_q), .at_bottom_q(at_bottom_q),
    .at_max_q(at_max_q), .timer_tick_q(timer_tick_q));
  t8cu_ext_source i_src (.core_clk(core_clk), .start(start), .pulse_count(pulse_count),
    .external_count_pin(external_count_pin), .busy(busy));

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (timer_tick_q === 1'b1) n_ticks++;
    if (at_max_q === 1'b1) n_max++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hangs are cut short here, counted as a mismatch
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    bus_req <= '0;
    #1 v = rd_data_q;
  endtask
  task automatic wait_on(input int sel, input int limit, output logic h);
    h = 1'b0;
    for (int i = 0; i < limit; i++) begin
      @(posedge core_clk);
      #1 h = sel == 0 ? at_max_q : sel == 1 ? at_bottom_q : sel == 2 ? irq_overflow_q : sel == 3 ? irq_compare_a_q : !busy;
      if (h === 1'b1) break;
    end
  endtask
  task automatic check_reset();
    for (int a = 0; a < 7; a++) begin
      rd(a[2:0], d);
      chk8("reset value", 8'h00, d);
    end
    chk1("at_bottom_q", 1'b1, at_bottom_q);
    $display("test reset done");
  endtask
  task automatic send_pulses(input logic [2:0] cs, input logic [7:0] n);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL_B, {5'h00, cs});
    mark = n_ticks;
    @(posedge core_clk);
    start <= 1'b1;
    pulse_count <= n;
    @(posedge core_clk);
    start <= 1'b0;
    wait_on(4, 200, hit);
    repeat (6) @(posedge core_clk);
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_COUNT, d);
    chk8("external count", n, d);
    chk8("timer_tick_q pulses", n, 8'(n_ticks - mark));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    check_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, d);
      chk8("register readback", rows[i].e, d);
    end
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CTRL_B, 8'h00);
    $display("test register table done");
    // Overflow in normal mode, then the same with its mask off
    wr(OFS_MASK, 8'h07);
    wr(OFS_COUNT, 8'hFD);
    wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    wait_on(0, 20, hit);
    chk1("at_max_q", 1'b1, hit);
    wait_on(1, 5, hit);
    chk1("at_bottom_q", 1'b1, hit);
    wait_on(2, 5, hit);
    chk1("irq_overflow_q", 1'b1, hit);
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_FLAG, d);
    chk1("overflow_flag", 1'b1, d[FLAG_OVF]);
    wr(OFS_FLAG, 8'h01);
    rd(OFS_FLAG, d);
    chk1("overflow_flag cleared", 1'b0, d[FLAG_OVF]);
    wr(OFS_MASK, 8'h00);
    wr(OFS_COUNT, 8'hFE);
    wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    repeat (10) @(posedge core_clk);
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_FLAG, d);
    chk1("masked overflow_flag", 1'b1, d[FLAG_OVF]);
    chk1("masked irq_overflow_q", 1'b0, irq_overflow_q);
    chk1("timer_tick_q", 1'b1, n_ticks > 0);
    $display("test overflow done");
    // Stopped timer makes no ticks and holds its count
    wr(OFS_FLAG, 8'h07);
    rd(OFS_COUNT, d);
    mark = n_ticks;
    repeat (30) @(posedge core_clk);
    rd(OFS_COUNT, d2);
    chk8("stopped count", d, d2);
    chk1("stopped tick", 1'b0, n_ticks != mark);
    $display("test stop done");
    // Count write equal to compare blocks the first match only
    wr(OFS_MASK, 8'h06);
    wr(OFS_CMP_A, 8'h05);
    wr(OFS_COUNT, 8'h05);
    wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    repeat (5) @(posedge core_clk);
    #1 chk1("blocked irq_compare_a_q", 1'b0, irq_compare_a_q);
    wait_on(3, 300, hit);
    chk1("irq_compare_a_q", 1'b1, hit);
    chk1("irq_compare_b_q", 1'b1, irq_compare_b_q);
    @(posedge core_clk);
    irq_ack <= 3'h6;
    @(posedge core_clk);
    irq_ack <= 3'h0;
    repeat (3) @(posedge core_clk);
    #1 chk1("acked irq_compare_a_q", 1'b0, irq_compare_a_q);
    chk1("acked irq_compare_b_q", 1'b0, irq_compare_b_q);
    // Write while running wins over the increment of that edge
    wr(OFS_COUNT, 8'h40);
    rd(OFS_COUNT, d);
    chk8("written count", 8'h41, d);
    $display("test compare done");
    // Clear on match keeps the count at or under compare A
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_A, {6'h00, WGM_CTC[1:0]});
    wr(OFS_CMP_A, 8'h03);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_FLAG, 8'h07);
    mark = n_max;
    wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    repeat (600) @(posedge core_clk);
    wr(OFS_CTRL_B, 8'h00);
    chk1("max in ctc", 1'b0, n_max != mark);
    rd(OFS_COUNT, d);
    chk1("count within top", 1'b1, d <= 8'h03);
    rd(OFS_FLAG, d);
    chk8("ctc flags", 8'h02, d & 8'h03);
    wr(OFS_CTRL_A, 8'h00);
    $display("test ctc done");
    // Phase correct: buffered compare loads at TOP, overflow at BOTTOM
    wr(OFS_CTRL_A, {6'h00, WGM_PC_MAX[1:0]});
    wr(OFS_CMP_A, 8'h50);
    wr(OFS_COUNT, 8'h01);
    wr(OFS_FLAG, 8'h07);
    wr(OFS_MASK, 8'h01);
    wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    repeat (4) @(posedge core_clk);
    rd(OFS_FLAG, d);
    chk8("pwm flags rising", 8'h02, d & 8'h03);
    wr(OFS_FLAG, 8'h02);
    wait_on(2, 600, hit);
    chk1("pwm irq_overflow_q", 1'b1, hit);
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_FLAG, d);
    chk8("pwm flags after top", 8'h03, d & 8'h03);
    // Fast mode with TOP from compare A wraps there
    wr(OFS_CTRL_A, 8'h03);
    wr(OFS_COUNT, 8'h4E);
    wr(OFS_FLAG, 8'h07);
    wr(OFS_CTRL_B, {4'h0, 1'b1, CS_DIV1});
    wait_on(2, 10, hit);
    chk1("fast irq_overflow_q", 1'b1, hit);
    wr(OFS_CTRL_B, 8'h08);
    rd(OFS_COUNT, d);
    chk1("fast wrap", 1'b1, d < 8'h10);
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CTRL_B, 8'h00);
    $display("test pwm done");
    // Prescaled sources: four periods of each divider
    for (int cs = 2; cs < 6; cs++) begin
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CTRL_B, cs[7:0]);
      repeat (4 << (cs == 2 ? 3 : cs == 3 ? 6 : cs == 4 ? 8 : 10)) @(posedge core_clk);
      wr(OFS_CTRL_B, 8'h00);
      rd(OFS_COUNT, d);
      chk1("prescaled count", 1'b1, d >= 8'h03 && d <= 8'h05);
    end
    $display("test prescaler done");
    send_pulses(CS_EXT_RISE, 8'h05);
    send_pulses(CS_EXT_FALL, 8'h03);
    $display("test external pin done");
    // Reset in mid-run
    wr(OFS_COUNT, 8'h77);
    wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    check_reset();
    conclude();
  end
endmodule
`default_nettype wire

/* test/t8cu_ext_source.sv */
// Behavioural external count source that drives the count pin with slow pulses
`timescale 1ns/1ps
`default_nettype none
module t8cu_ext_source (
  input wire logic core_clk,
  input wire logic start,
  input wire logic [7:0] pulse_count,
  output logic external_count_pin,
  output logic busy
);
  // Each level lasts three clocks so the synchroniser cannot lose an edge
  initial begin
    external_count_pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (start) begin
        busy = 1'b1;
        repeat (pulse_count) begin
          #3 external_count_pin = 1'b1;
          repeat (3) @(posedge core_clk);
          #3 external_count_pin = 1'b0;
          repeat (3) @(posedge core_clk);
        end
        busy = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
